/* rtl/stpb_defines.vh */
/*
 parameter offsets, reset values, ranges, command codes and timing counts
 for the servo tuning parameter bank.
 assumes it is included by its bare name and holds definitions only.
*/
`ifndef STPB_DEFINES_VH
`define STPB_DEFINES_VH
// word addresses of the bank
`define STPB_ADDR_RATE 16'h020a
`define STPB_ADDR_KINT 16'h020c
`define STPB_ADDR_FFWD 16'h020e
`define STPB_ADDR_CMD 16'h0210
`define STPB_ADDR_DEB 16'h0212
// reset values
`define STPB_RST_RATE 16'h0064
`define STPB_RST_KINT 16'h0064
`define STPB_RST_FFWD 16'h0000
`define STPB_RST_CMD 16'h0000
`define STPB_RST_DEB 16'h0002
// accepted ranges
`define STPB_RATE_MIN 16'h000a
`define STPB_RATE_MAX 16'h01f4
`define STPB_KINT_MAX 16'h03ff
`define STPB_FFWD_MAX 16'h0064
`define STPB_DEB_MAX 16'h0014
// command codes
`define STPB_CMD_FACTORY 16'h000a
`define STPB_CMD_EXTRA 16'h0014
`define STPB_CMD_BLOCK 16'h0016
`define STPB_CMD_FORCE_ON 16'h0196
`define STPB_CMD_FORCE_OFF 16'h0190
// debounce step: 2 ms at 100 MHz
`define STPB_STEP_MS 2
`define STPB_CLK_MHZ 100
`define STPB_STEP_CYC (`STPB_STEP_MS * 1000 * `STPB_CLK_MHZ)
// one percent scale for the gain product
`define STPB_PCT 16'h0064
`endif

/* rtl/stpb_debounce.v */
/*
 one digital input debouncer: three-flop synchroniser plus a hold counter
 counted in 2 ms step pulses.
 assumes step_i is a one-cycle pulse from a shared divider on clk_i.
*/
`default_nettype none
module stpb_debounce (
  input wire clk_i,
  input wire rst_i,
  input wire din_i, // raw pin, asynchronous
  input wire step_i, // one pulse per 2 ms
  input wire [4:0] steps_i, // filter length in steps
  output reg dout_o // filtered level
);
  reg s1_r; // first stage, read only by s2_r
  reg s2_r;
  reg s3_r;
  reg [4:0] cnt_r; // steps the new level has held
  // synchroniser chain
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end
    else
    begin
      s1_r <= din_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a change counts once s2 and s3 agree and differ from the output
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 5'h00;
      dout_o <= 1'b0;
    end
    else if (s2_r != s3_r || s3_r == dout_o)
      cnt_r <= 5'h00; // unstable or no change: restart
    else if (cnt_r >= steps_i)
    begin
      dout_o <= s3_r;
      cnt_r <= 5'h00;
    end
    else if (step_i)
      cnt_r <= cnt_r + 5'h01;
  end
endmodule // stpb_debounce
`default_nettype wire

/* rtl/stpb_bank.v */
/*
 servo tuning parameter bank: 16-bit parameter words written from the
 keypad or serial link, range checked, plus the special command decode,
 scaled speed gain and debounced digital inputs.
 assumes wr_i/rd_i are one-cycle strobes synchronous to clk_i and that
 factory reset is acted on by the power-up loader via factory_pend_o.
*/
// How it works
// - rate 10..500 applied only while switching
// - integral gain 0..1023 stored, output
// - feed-forward 0..100, default zero, applied
// - code 10 flags factory reset next power-up; ignored while servo is on
// - code 20 unlocks extra group-four parameter
// - code 22 unlocks group-four parameters 11..19
// - code 406 enters forced output mode
// - code 400 leaves forced output mode
// - inputs filtered for setting times 2 ms
`default_nettype none
`include "stpb_defines.vh"
module stpb_bank (
  input wire clk_i,
  input wire rst_i,
  input wire wr_i, // write strobe
  input wire rd_i, // read strobe
  input wire [15:0] addr_i, // parameter word address
  input wire [15:0] wdata_i, // write value
  output reg [15:0] rdata_o, // read value
  output reg rvalid_o, // read answer pulse
  output reg wr_ack_o, // write accepted pulse
  output reg wr_err_o, // write refused pulse
  input wire servo_on_i, // drive enabled
  input wire gain_switch_condition_i, // switching condition met
  input wire [15:0] base_gain_i, // unscaled speed gain
  output reg [15:0] gain_o, // speed gain to the loop
  output reg [15:0] speed_integral_gain_o,
  output reg [15:0] speed_feedforward_o,
  output reg factory_pend_o, // restore defaults at next power-up
  output reg group4_extra_param_en_o,
  output reg group4_block_en_o,
  output reg force_out_o, // forced digital output mode
  input wire [7:0] forced_do_i, // forced output pattern
  input wire [7:0] normal_do_i, // normal function outputs
  output reg [7:0] do_o, // digital outputs
  input wire [7:0] di_i, // raw digital inputs
  output reg [7:0] di_o // debounced inputs
);
  localparam [31:0] STEP_CYC = `STPB_STEP_CYC;
  reg [15:0] gain_switch_rate_r;
  reg [15:0] speed_integral_gain_r;
  reg [15:0] speed_feedforward_r;
  reg [15:0] special_command_r;
  reg [15:0] debounce_time_r;
  reg force_r; // forced output latch
  reg [31:0] div_r; // 2 ms step divider
  reg step_r; // one-cycle step pulse
  wire [7:0] di_f; // filtered inputs
  wire [31:0] prod; // base gain times rate
  wire [31:0] scaled; // prod over one hundred
  wire in_range; // write value legal for target
  wire hit; // address maps to the bank

  // legal-range check per address, used for write refusal
  function range_ok;
    input [15:0] a;
    input [15:0] v;
    begin
      case (a)
        `STPB_ADDR_RATE: range_ok = (v >= `STPB_RATE_MIN) && (v <= `STPB_RATE_MAX);
        `STPB_ADDR_KINT: range_ok = (v <= `STPB_KINT_MAX);
        `STPB_ADDR_FFWD: range_ok = (v <= `STPB_FFWD_MAX);
        `STPB_ADDR_CMD: range_ok = 1'b1; // full 16-bit range
        `STPB_ADDR_DEB: range_ok = (v <= `STPB_DEB_MAX);
        default: range_ok = 1'b0;
      endcase
    end
  endfunction

  // address decode, used only for the read port's default answer
  function is_mapped;
    input [15:0] a;
    begin
      is_mapped = (a == `STPB_ADDR_RATE) || (a == `STPB_ADDR_KINT) ||
        (a == `STPB_ADDR_FFWD) || (a == `STPB_ADDR_CMD) || (a == `STPB_ADDR_DEB);
    end
  endfunction

  assign in_range = range_ok(addr_i, wdata_i);
  assign hit = is_mapped(addr_i);

  // parameter storage; refused writes keep the old word
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gain_switch_rate_r <= `STPB_RST_RATE;
      speed_integral_gain_r <= `STPB_RST_KINT;
      speed_feedforward_r <= `STPB_RST_FFWD;
      special_command_r <= `STPB_RST_CMD;
      debounce_time_r <= `STPB_RST_DEB;
      wr_ack_o <= 1'b0;
      wr_err_o <= 1'b0;
    end
    else
    begin
      wr_ack_o <= wr_i && in_range;
      wr_err_o <= wr_i && !in_range;
      if (wr_i && in_range)
      begin
        case (addr_i)
          `STPB_ADDR_RATE: gain_switch_rate_r <= wdata_i;
          `STPB_ADDR_KINT: speed_integral_gain_r <= wdata_i;
          `STPB_ADDR_FFWD: speed_feedforward_r <= wdata_i;
          `STPB_ADDR_CMD: special_command_r <= wdata_i;
          `STPB_ADDR_DEB: debounce_time_r <= wdata_i;
          default: ; // unreachable: range_ok refuses unmapped
        endcase
      end
    end
  end

  // command side effects; factory code accepted but ignored while servo is on
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      factory_pend_o <= 1'b0;
      force_r <= 1'b0;
    end
    else if (wr_i && addr_i == `STPB_ADDR_CMD)
    begin
      case (wdata_i)
        `STPB_CMD_FACTORY:
          if (!servo_on_i)
            factory_pend_o <= 1'b1; // held until power cycle
        `STPB_CMD_FORCE_ON: force_r <= 1'b1;
        `STPB_CMD_FORCE_OFF: force_r <= 1'b0;
        default: ; // no special effect
      endcase
    end
  end

  // unlock levels follow the held command word
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      group4_extra_param_en_o <= 1'b0;
      group4_block_en_o <= 1'b0;
      force_out_o <= 1'b0;
    end
    else
    begin
      group4_extra_param_en_o <= (special_command_r == `STPB_CMD_EXTRA);
      group4_block_en_o <= (special_command_r == `STPB_CMD_BLOCK);
      force_out_o <= force_r;
    end
  end

  // gain scaling; divide by a constant, synthesis maps it to multiply
  assign prod = base_gain_i * gain_switch_rate_r;
  assign scaled = prod / {16'h0000, `STPB_PCT};

  // loop-facing outputs, all registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      gain_o <= 16'h0000;
      speed_integral_gain_o <= `STPB_RST_KINT;
      speed_feedforward_o <= `STPB_RST_FFWD;
      do_o <= 8'h00;
      di_o <= 8'h00;
    end
    else
    begin
      // saturate: a 500 percent rate can overflow 16 bits
      if (gain_switch_condition_i)
        gain_o <= (scaled[31:16] != 16'h0000) ? 16'hffff : scaled[15:0];
      else
        gain_o <= base_gain_i;
      speed_integral_gain_o <= speed_integral_gain_r;
      speed_feedforward_o <= speed_feedforward_r;
      do_o <= force_r ? forced_do_i : normal_do_i;
      di_o <= di_f;
    end
  end

  // register read port; unmapped reads answer zero
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o <= 16'h0000;
      rvalid_o <= 1'b0;
    end
    else
    begin
      rvalid_o <= rd_i;
      if (rd_i)
      begin
        case (addr_i)
          `STPB_ADDR_RATE: rdata_o <= gain_switch_rate_r;
          `STPB_ADDR_KINT: rdata_o <= speed_integral_gain_r;
          `STPB_ADDR_FFWD: rdata_o <= speed_feedforward_r;
          `STPB_ADDR_CMD: rdata_o <= special_command_r;
          `STPB_ADDR_DEB: rdata_o <= debounce_time_r;
          default: rdata_o <= hit ? 16'hffff : 16'h0000;
        endcase
      end
    end
  end

  // 2 ms step divider shared by all input filters
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_r <= 32'h00000000;
      step_r <= 1'b0;
    end
    else if (div_r == STEP_CYC - 32'h00000001)
    begin
      div_r <= 32'h00000000;
      step_r <= 1'b1;
    end
    else
    begin
      div_r <= div_r + 32'h00000001;
      step_r <= 1'b0;
    end
  end

  // one filter per digital input
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_deb
      stpb_debounce u_deb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .din_i(di_i[gi]),
        .step_i(step_r),
        .steps_i(debounce_time_r[4:0]),
        .dout_o(di_f[gi])
      );
    end
  endgenerate
endmodule // stpb_bank
`default_nettype wire

/* dv/stpb_bank_props.sv */
/* checker for the parameter bank: write answers and command codes.
   assumes it is bound to stpb_bank and sees only its ports. */
`default_nettype none
`include "stpb_defines.vh"
module stpb_bank_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [15:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic servo_on_i,
  input wire logic wr_ack_o,
  input wire logic wr_err_o,
  input wire logic factory_pend_o,
  input wire logic force_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // decoded write targets
  wire logic wc = wr_i && addr_i == `STPB_ADDR_CMD;
  wire logic wrt = wr_i && addr_i == `STPB_ADDR_RATE;
  force_on_a: assert property (
    wc && wdata_i == `STPB_CMD_FORCE_ON |=> wr_ack_o ##1 force_out_o)
    else $error("forced mode not entered");
  force_off_a: assert property (
    wc && wdata_i == `STPB_CMD_FORCE_OFF |=> ##1 !force_out_o)
    else $error("forced mode not left");
  factory_flag_a: assert property (
    wc && wdata_i == `STPB_CMD_FACTORY && !servo_on_i |=> ##[0:1] factory_pend_o)
    else $error("factory flag missing");
  cmd_any_a: assert property (wc |=> wr_ack_o && !wr_err_o)
    else $error("command word refused");
  rate_low_a: assert property (wrt && wdata_i < `STPB_RATE_MIN |=> wr_err_o)
    else $error("low rate accepted");
  rate_high_a: assert property (wrt && wdata_i > `STPB_RATE_MAX |=> wr_err_o)
    else $error("high rate accepted");
  integ_range_a: assert property (
    wr_i && addr_i == `STPB_ADDR_KINT && wdata_i > `STPB_KINT_MAX |=> wr_err_o)
    else $error("integral out of range accepted");
  ffwd_range_a: assert property (
    wr_i && addr_i == `STPB_ADDR_FFWD && wdata_i > `STPB_FFWD_MAX |=> wr_err_o)
    else $error("feed-forward out of range accepted");
endmodule // stpb_bank_props
bind stpb_bank stpb_bank_props stpb_bank_props_i (.clk_i(clk_i), .rst_i(rst_i),
  .wr_i(wr_i), .addr_i(addr_i), .wdata_i(wdata_i), .servo_on_i(servo_on_i),
  .wr_ack_o(wr_ack_o), .wr_err_o(wr_err_o), .factory_pend_o(factory_pend_o),
  .force_out_o(force_out_o));
`default_nettype wire

/* dv/stpb_host.sv */
/* host model: keypad or serial writer of parameter words.
   assumes the bank's clock and a bench that pops its queues. */
`default_nettype none
module stpb_host (
  input wire logic clk_i,
  output logic wr_o,
  output logic rd_o,
  output logic [15:0] addr_o,
  output logic [15:0] wdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wq[$]; // expected refusal per write
  logic [15:0] rq[$]; // expected read data
  initial
  begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 16'h0000;
    wdata_o = 16'h0000;
  end
  // one strobe cycle; released bus shows the inverse so stale data never passes
  task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    wr_o = w;
    rd_o = !w;
    addr_o = a;
    wdata_o = d;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic put(input logic [15:0] a, input logic [15:0] d, input logic e);
    wq.push_back(e);
    xfer(1'b1, a, d);
  endtask
  task automatic get(input logic [15:0] a, input logic [15:0] d);
    rq.push_back(d);
    xfer(1'b0, a, 16'h0000);
  endtask
endmodule // stpb_host
`default_nettype wire

/* dv/testbench.sv */
/* bench for the parameter bank: ranges, commands, gain and outputs.
   assumes the host model and the bound checker. */
`default_nettype none
`include "stpb_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic son = 1'b0; // servo on
  logic cond = 1'b0; // switching condition
  logic [15:0] base = 16'h0032; // unscaled gain
  logic [7:0] fdo = 8'h5a;
  logic [7:0] ndo = 8'ha5;
  logic [7:0] din = 8'h00; // raw digital inputs, idle low like the filter after reset
  logic [15:0] r, f;
  wire logic wr, rd, rv, ack, err, pend, xen, ben, frc;
  wire logic [15:0] adr, wd, rdat, gain, kint, ffwd;
  wire logic [7:0] dout;
  wire logic [7:0] dfil; // debounced inputs
  int fail_count = 0, total_checks = 0, cyc = 0, seed = 16;
  stpb_bank stpb_bank_i (.clk_i(clk), .rst_i(rst), .wr_i(wr), .rd_i(rd), .addr_i(adr),
    .wdata_i(wd), .rdata_o(rdat), .rvalid_o(rv), .wr_ack_o(ack), .wr_err_o(err),
    .servo_on_i(son), .gain_switch_condition_i(cond), .base_gain_i(base), .gain_o(gain),
    .speed_integral_gain_o(kint), .speed_feedforward_o(ffwd), .factory_pend_o(pend),
    .group4_extra_param_en_o(xen), .group4_block_en_o(ben), .force_out_o(frc),
    .forced_do_i(fdo), .normal_do_i(ndo), .do_o(dout), .di_i(din), .di_o(dfil));
  stpb_host stpb_host_i (.clk_i(clk), .wr_o(wr), .rd_o(rd), .addr_o(adr), .wdata_o(wd));
  initial
  begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // registered outputs land well before the falling edge
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // answers are settled mid-cycle; oldest note first
  always @(negedge clk)
  begin
    if (ack | err)
      chk({15'h0000, err}, {15'h0000, stpb_host_i.wq.pop_front()});
    if (rv)
      chk(rdat, stpb_host_i.rq.pop_front());
  end
  // hang guard, far above the roughly 140 cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      end_of_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    stpb_host_i.get(`STPB_ADDR_RATE, `STPB_RST_RATE);
    stpb_host_i.get(`STPB_ADDR_KINT, `STPB_RST_KINT);
    stpb_host_i.get(`STPB_ADDR_FFWD, `STPB_RST_FFWD);
    stpb_host_i.get(`STPB_ADDR_CMD, `STPB_RST_CMD);
    stpb_host_i.get(`STPB_ADDR_DEB, `STPB_RST_DEB);
    stpb_host_i.put(`STPB_ADDR_RATE, 16'h0009, 1'b1);
    stpb_host_i.put(`STPB_ADDR_RATE, 16'h000a, 1'b0);
    stpb_host_i.put(`STPB_ADDR_RATE, 16'h01f5, 1'b1);
    stpb_host_i.put(`STPB_ADDR_RATE, 16'h01f4, 1'b0);
    stpb_host_i.get(`STPB_ADDR_RATE, 16'h01f4);
    stpb_host_i.put(`STPB_ADDR_KINT, 16'h0400, 1'b1);
    stpb_host_i.put(`STPB_ADDR_KINT, 16'h03ff, 1'b0);
    stpb_host_i.put(`STPB_ADDR_DEB, 16'h0015, 1'b1);
    stpb_host_i.put(`STPB_ADDR_DEB, 16'h0014, 1'b0);
    stpb_host_i.put(16'h0214, 16'h0001, 1'b1);
    stpb_host_i.get(16'h0214, 16'h0000);
    settle();
    chk(kint, 16'h03ff);
    cond = 1'b1;
    settle();
    chk(gain, 16'h00fa);
    // full-scale gain at 500 percent must clip, not wrap
    base = 16'hffff;
    settle();
    chk(gain, 16'hffff);
    cond = 1'b0;
    settle();
    chk(gain, base);
    son = 1'b1;
    stpb_host_i.put(`STPB_ADDR_CMD, `STPB_CMD_FACTORY, 1'b0);
    settle();
    chk(pend, 16'h0000);
    son = 1'b0;
    stpb_host_i.put(`STPB_ADDR_CMD, `STPB_CMD_FACTORY, 1'b0);
    settle();
    chk(pend, 16'h0001);
    stpb_host_i.put(`STPB_ADDR_CMD, `STPB_CMD_EXTRA, 1'b0);
    settle();
    chk({xen, ben}, 16'h0002);
    stpb_host_i.put(`STPB_ADDR_CMD, `STPB_CMD_BLOCK, 1'b0);
    settle();
    chk({xen, ben}, 16'h0001);
    stpb_host_i.put(`STPB_ADDR_CMD, `STPB_CMD_FORCE_ON, 1'b0);
    settle();
    chk({frc, dout}, {7'h00, 1'b1, fdo});
    stpb_host_i.put(`STPB_ADDR_CMD, 16'h0007, 1'b0);
    settle();
    chk({xen, ben, frc}, 16'h0001);
    stpb_host_i.put(`STPB_ADDR_CMD, `STPB_CMD_FORCE_OFF, 1'b0);
    settle();
    chk({frc, dout}, {8'h00, ndo});
    // zero filter time: only the synchroniser and the dout_o and di_o registers stand between pin and output
    stpb_host_i.put(`STPB_ADDR_DEB, 16'h0000, 1'b0);
    din = 8'($random(seed));
    r = {8'h00, din};
    repeat (6) @(posedge clk);
    #1;
    chk({8'h00, dfil}, r);
    // a one-cycle bounce never lets two sync stages agree, so it must not pass
    din = ~din;
    @(posedge clk);
    #1 din = ~din;
    repeat (6) @(posedge clk);
    #1;
    chk({8'h00, dfil}, r);
    // random feed-forward words, about a fifth above the range
    f = `STPB_RST_FFWD;
    repeat (12)
    begin
      r = $random(seed);
      r = {9'h000, r[6:0]};
      stpb_host_i.put(`STPB_ADDR_FFWD, r, r > `STPB_FFWD_MAX);
      if (r <= `STPB_FFWD_MAX)
        f = r;
      stpb_host_i.get(`STPB_ADDR_FFWD, f);
    end
    settle();
    chk(ffwd, f);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
